// ===== schf_pkg.sv
// Package for the staged configuration handoff block.
// Holds register offsets, field positions, reset values and the phase encoding.
package schf_pkg;

  localparam logic [7:0] SCHF_OFS_CTRL   = 8'h00;
  localparam logic [7:0] SCHF_OFS_STATUS = 8'h04;
  localparam logic [7:0] SCHF_OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] SCHF_OFS_IRQ_MK = 8'h0C;

  // Control fields
  localparam int SCHF_CTRL_SRST  = 0;
  localparam int SCHF_CTRL_LINK  = 1;
  localparam int SCHF_CTRL_SRC   = 2;
  localparam int SCHF_CTRL_START = 3;

  // Status fields
  localparam int SCHF_ST_READY = 0;
  localparam int SCHF_ST_EOS   = 1;
  localparam int SCHF_ST_LNK   = 2;
  localparam int SCHF_ST_DONE  = 3;
  localparam int SCHF_ST_RST   = 4;
  localparam int SCHF_ST_PHASE = 5;

  // Interrupt events
  localparam int SCHF_EV_S1    = 0;
  localparam int SCHF_EV_S2    = 1;
  localparam int SCHF_EV_LNKUP = 2;
  localparam int SCHF_EV_LNKDN = 3;
  localparam int SCHF_NEV      = 4;

  localparam logic [31:0] SCHF_CTRL_RST = 32'h0000_0000;
  localparam logic [3:0]  SCHF_MASK_RST = 4'h0;
  localparam logic [1:0]  SCHF_RESP_OK  = 2'b00;
  localparam logic [1:0]  SCHF_RESP_ERR = 2'b10;
  localparam int          SCHF_RST_CYC  = 4;

  typedef enum logic [1:0] {
    SCHF_PH_UNCFG = 2'b00,
    SCHF_PH_S1    = 2'b01,
    SCHF_PH_LOAD2 = 2'b10,
    SCHF_PH_S2    = 2'b11
  } schf_phase_t;

endpackage

// ===== schf_io_if.sv
// Interface between the handoff sequencer and the register slave.
// Assumes both ends share aclk.
`timescale 1ns/10ps
interface schf_io_if;
  import schf_pkg::*;
  logic [31:0]         ctrl;
  logic [3:0]          mask;
  logic [SCHF_NEV-1:0] event_p;
  logic [SCHF_NEV-1:0] irq_stat;
  logic [5:0]          status;
  modport seq (input ctrl, input mask, output event_p, output status, input irq_stat);
  modport regs (output ctrl, output mask, input event_p, input status, output irq_stat);
endinterface

// ===== schf_axil_regs.sv
// AXI4-Lite register slave for the handoff block.
// Assumes a single aclk domain; one write and one read in flight at a time.
`timescale 1ns/10ps
module schf_axil_regs
  import schf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  schf_io_if.regs          io,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);
  logic              aw_got_r;
  logic              w_got_r;
  logic [7:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic [31:0]       ctrl_r;
  logic [3:0]        mask_r;
  logic [SCHF_NEV-1:0] stat_r;
  logic              do_wr;
  logic [31:0]       wmask;

  assign s_awready   = ce && !aw_got_r && !s_bvalid;
  assign s_wready    = ce && !w_got_r && !s_bvalid;
  assign s_arready   = ce && !s_rvalid;
  assign do_wr       = ce && aw_got_r && w_got_r && !s_bvalid;
  assign wmask       = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign io.ctrl     = ctrl_r;
  assign io.mask     = mask_r;
  assign io.irq_stat = stat_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (ce) begin
      if (s_awvalid && s_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= SCHF_CTRL_RST;
      mask_r   <= SCHF_MASK_RST;
      s_bvalid <= 1'b0;
      s_bresp  <= SCHF_RESP_OK;
    end else if (ce) begin
      if (s_bvalid && s_bready) s_bvalid <= 1'b0;
      if (do_wr) begin
        s_bvalid <= 1'b1;
        s_bresp  <= SCHF_RESP_OK;
        case (awaddr_r[7:2])
          SCHF_OFS_CTRL[7:2]:   ctrl_r <= (ctrl_r & ~wmask) | (wdata_r & wmask);
          SCHF_OFS_IRQ_MK[7:2]: if (wstrb_r[0]) mask_r <= wdata_r[3:0];
          SCHF_OFS_IRQ_ST[7:2]: ;
          SCHF_OFS_STATUS[7:2]: ;
          default:              s_bresp <= SCHF_RESP_ERR;
        endcase
      end
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= '0;
    end else if (ce) begin
      if (do_wr && awaddr_r[7:2] == SCHF_OFS_IRQ_ST[7:2] && wstrb_r[0])
        stat_r <= (stat_r & ~wdata_r[SCHF_NEV-1:0]) | io.event_p;
      else
        stat_r <= stat_r | io.event_p;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= SCHF_RESP_OK;
    end else if (ce) begin
      if (s_rvalid && s_rready) s_rvalid <= 1'b0;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp  <= SCHF_RESP_OK;
        case (s_araddr[7:2])
          SCHF_OFS_CTRL[7:2]:   s_rdata <= ctrl_r;
          SCHF_OFS_STATUS[7:2]: s_rdata <= {26'h000_0000, io.status};
          SCHF_OFS_IRQ_ST[7:2]: s_rdata <= {28'h000_0000, stat_r};
          SCHF_OFS_IRQ_MK[7:2]: s_rdata <= {28'h000_0000, mask_r};
          default: begin
            s_rdata <= 32'h0000_0000;
            s_rresp <= SCHF_RESP_ERR;
          end
        endcase
      end
    end
  end
endmodule

// ===== schf_handoff.sv
// Staged configuration handoff: sequences stage one, stage two load and the
// switch of the link block to user logic. Assumes aclk is the core clock.
`timescale 1ns/10ps
module schf_handoff
  import schf_pkg::*;
#(
  parameter int NCRIT = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             eos_in,
  input  wire logic             stage2_load_start,
  input  wire logic             link_ok,
  input  wire logic             pullup_during_config_n,
  input  wire logic [NCRIT-1:0] user_crit_in,
  output logic [NCRIT-1:0]      core_crit_out,
  input  wire logic             tlp_unhandled,
  output logic                  tlp_unsupported,
  output logic                  tlp_to_user,
  input  wire logic             shared_out_data,
  output logic                  shared_out_o,
  output logic                  shared_out_oe,
  output logic                  free_io_pullup,
  output logic                  free_io_pulldown,
  output logic                  design_switch,
  output logic                  eos_out,
  output logic                  config_done,
  output logic                  user_reset,
  output logic                  user_lnk_up,
  output logic                  irq,
  input  wire logic [7:0]       s_awaddr,
  input  wire logic             s_awvalid,
  output logic                  s_awready,
  input  wire logic [31:0]      s_wdata,
  input  wire logic [3:0]       s_wstrb,
  input  wire logic             s_wvalid,
  output logic                  s_wready,
  output logic [1:0]            s_bresp,
  output logic                  s_bvalid,
  input  wire logic             s_bready,
  input  wire logic [7:0]       s_araddr,
  input  wire logic             s_arvalid,
  output logic                  s_arready,
  output logic [31:0]           s_rdata,
  output logic [1:0]            s_rresp,
  output logic                  s_rvalid,
  input  wire logic             s_rready
);
  schf_io_if io ();

  schf_axil_regs u_regs (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .io        (io),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready)
  );

  // Pin-level inputs pass two flops before use
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic       eos_s;
  logic       load_s;
  logic       link_s;
  logic       pudc_n_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else if (ce) begin
      sync1_r <= {pullup_during_config_n, link_ok, stage2_load_start, eos_in};
      sync2_r <= sync1_r;
    end
  end
  assign eos_s    = sync2_r[0];
  assign load_s   = sync2_r[1];
  assign link_s   = sync2_r[2];
  assign pudc_n_s = sync2_r[3];

  schf_phase_t phase_r;
  schf_phase_t phase_nxt;
  logic        eos_d_r;
  logic        eos_rise;
  logic        load_req;
  logic        user_rst_cond;
  logic        link_d_r;

  assign eos_rise = eos_s && !eos_d_r;
  // Load may begin from the pin or from software (stored-flash case)
  assign load_req = load_s || io.ctrl[SCHF_CTRL_START];

  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      SCHF_PH_UNCFG: if (eos_rise) phase_nxt = SCHF_PH_S1;
      SCHF_PH_S1:    if (load_req) phase_nxt = SCHF_PH_LOAD2;
      SCHF_PH_LOAD2: if (eos_rise) phase_nxt = SCHF_PH_S2;
      SCHF_PH_S2:    phase_nxt = SCHF_PH_S2;
      default:       phase_nxt = SCHF_PH_UNCFG;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= SCHF_PH_UNCFG;
      eos_d_r <= 1'b0;
    end else if (ce) begin
      phase_r <= phase_nxt;
      eos_d_r <= eos_s;
    end
  end

  // Ready is a flop of the terminal phase only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      design_switch <= 1'b0;
    end else if (ce) begin
      design_switch <= (phase_nxt == SCHF_PH_S2);
    end
  end

  // Same level as the pin, delayed by the synchroniser and one more flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eos_out <= 1'b0;
    end else if (ce) begin
      eos_out <= eos_s;
    end
  end

  // Done: pulse at stage one, low during load, high for good after stage two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_done <= 1'b0;
    end else if (ce) begin
      case (phase_nxt)
        SCHF_PH_S1:    config_done <= (phase_r == SCHF_PH_UNCFG);
        SCHF_PH_LOAD2: config_done <= 1'b0;
        SCHF_PH_S2:    config_done <= 1'b1;
        default:       config_done <= 1'b0;
      endcase
    end
  end

  // Reset stretched for a few cycles, released synchronously
  logic [2:0] rst_cnt_r;
  assign user_rst_cond = io.ctrl[SCHF_CTRL_SRST];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_r  <= 3'(SCHF_RST_CYC);
      user_reset <= 1'b1;
    end else if (ce) begin
      if (user_rst_cond) begin
        rst_cnt_r <= 3'(SCHF_RST_CYC);
      end else if (rst_cnt_r != 3'd0) begin
        rst_cnt_r <= rst_cnt_r - 3'd1;
      end
      user_reset <= user_rst_cond || (rst_cnt_r != 3'd0);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_lnk_up <= 1'b0;
      link_d_r    <= 1'b0;
    end else if (ce) begin
      user_lnk_up <= link_s && io.ctrl[SCHF_CTRL_LINK] && !user_reset;
      link_d_r    <= user_lnk_up;
    end
  end

  // Critical inputs forced low until handoff, one mux per bit
  genvar gi;
  generate
    for (gi = 0; gi < NCRIT; gi++) begin : g_crit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          core_crit_out[gi] <= 1'b0;
        end else if (ce) begin
          core_crit_out[gi] <= design_switch & user_crit_in[gi];
        end
      end
    end
  endgenerate

  // Requests the hard block does not consume
  assign tlp_unsupported = tlp_unhandled && !design_switch;
  assign tlp_to_user     = tlp_unhandled && design_switch;

  // Shared-bank output held tristate until ready; before stage one it floats
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shared_out_o  <= 1'b0;
      shared_out_oe <= 1'b0;
    end else if (ce) begin
      shared_out_o  <= shared_out_data;
      shared_out_oe <= design_switch;
    end
  end

  // Weak pulls on unconfigured user pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_io_pullup   <= 1'b0;
      free_io_pulldown <= 1'b0;
    end else if (ce) begin
      free_io_pulldown <= (phase_nxt == SCHF_PH_S1);
      free_io_pullup   <= (phase_nxt == SCHF_PH_LOAD2) && !pudc_n_s;
    end
  end

  // Events for the interrupt status register
  // One process owns the whole vector, so it has a single driver
  always_comb begin
    io.event_p                   = '0;
    io.event_p[SCHF_EV_S1]       = (phase_r == SCHF_PH_UNCFG) && (phase_nxt == SCHF_PH_S1) && ce;
    io.event_p[SCHF_EV_S2]       = (phase_r == SCHF_PH_LOAD2) && (phase_nxt == SCHF_PH_S2) && ce;
    io.event_p[SCHF_EV_LNKUP]    = user_lnk_up && !link_d_r && ce;
    io.event_p[SCHF_EV_LNKDN]    = !user_lnk_up && link_d_r && ce;
  end
  assign io.status = {phase_r == SCHF_PH_LOAD2, user_reset, config_done, user_lnk_up, eos_out, design_switch};
  assign irq       = |(io.irq_stat & io.mask);

  // Assertions
  AST_READY_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    design_switch |=> design_switch) else $error("ready dropped");
  AST_READY_PHASE: assert property (@(posedge aclk) disable iff (!aresetn)
    design_switch |-> phase_r == SCHF_PH_S2) else $error("ready outside stage two");
  AST_SWITCH_EOS: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && phase_r == SCHF_PH_LOAD2 && eos_s && !eos_d_r) |=> design_switch)
    else $error("no switch on end-of-startup");
  AST_EOS_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
    ce |=> eos_out == $past(eos_s)) else $error("pass-through mismatch");
  AST_DONE_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && config_done && phase_r == SCHF_PH_S1) ##1 ce |-> !config_done)
    else $error("stage one done not a pulse");
  AST_DONE_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_r == SCHF_PH_LOAD2 |-> !config_done) else $error("done high while loading");
  AST_DONE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    design_switch |-> config_done) else $error("done not held");
  AST_RST_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && user_rst_cond) |=> user_reset) else $error("reset not asserted");
  AST_RST_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !user_rst_cond && rst_cnt_r == 3'd0) |=> !user_reset) else $error("reset held too long");
  AST_LINK: assert property (@(posedge aclk) disable iff (!aresetn)
    user_lnk_up |-> $past(link_s)) else $error("link-up without link");
  AST_CRIT: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(design_switch) |-> core_crit_out == '0) else $error("critical input leaked");
  AST_TLP_UR: assert property (@(posedge aclk) disable iff (!aresetn)
    (tlp_unhandled && !design_switch) |-> tlp_unsupported && !tlp_to_user)
    else $error("request not refused");
  AST_OE: assert property (@(posedge aclk) disable iff (!aresetn)
    shared_out_oe |-> $past(design_switch)) else $error("shared output enabled early");
  AST_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
    !(free_io_pullup && free_io_pulldown)) else $error("both pulls on");
  // Pull and shared-output enable may only show in their own phase; end-of-startup stays low before stage one
  AST_EOS_UNCFG: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_r == SCHF_PH_UNCFG |-> !eos_out) else $error("end-of-startup before stage one");
  AST_PULLDOWN_PH: assert property (@(posedge aclk) disable iff (!aresetn)
    free_io_pulldown |-> phase_r == SCHF_PH_S1) else $error("pull-down outside stage one");
  AST_PULLUP_PH: assert property (@(posedge aclk) disable iff (!aresetn)
    free_io_pullup |-> phase_r == SCHF_PH_LOAD2) else $error("pull-up outside stage two load");
  AST_OE_PHASE: assert property (@(posedge aclk) disable iff (!aresetn)
    shared_out_oe |-> phase_r == SCHF_PH_S2) else $error("shared output driven before stage two");
endmodule

// ===== schf_user_model.sv
// Stage-two user logic seen from the handoff block.
// Assumes it runs on the core clock and is reset by the block's user reset.
`timescale 1ns/10ps
module schf_user_model (
  input  wire logic       aclk,
  input  wire logic       user_reset,
  output logic      [3:0] user_crit_in,
  output logic            shared_out_data
);
  logic [3:0] cnt_r;

  // Changes every cycle so a stale or frozen copy shows at once
  always_ff @(posedge aclk) begin
    if (user_reset) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  assign user_crit_in    = cnt_r;
  assign shared_out_data = cnt_r[0];
endmodule

// ===== staged_config_handoff_tb.sv
// Self-checking bench for the staged configuration handoff block.
// Assumes a 200 MHz core clock and an AXI4-Lite master driven from here.
`timescale 1ns/10ps
module staged_config_handoff_tb;
  import schf_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
  } schf_row_t;
  schf_row_t rows [6] = '{'{8'h00, SCHF_CTRL_RST, SCHF_RESP_OK}, '{8'h04, 32'h0000_0000, SCHF_RESP_OK},
    '{8'h08, 32'h0000_0000, SCHF_RESP_OK}, '{8'h0C, 32'h0000_0000, SCHF_RESP_OK},
    '{8'h10, 32'h0000_0000, SCHF_RESP_ERR}, '{8'h20, 32'h0000_0000, SCHF_RESP_ERR}};
  logic        aclk, aresetn, ce, eos_in, stage2_load_start, link_ok, pullup_during_config_n;
  logic [3:0]  user_crit_in, core_crit_out, s_wstrb;
  logic        tlp_unhandled, tlp_unsupported, tlp_to_user, shared_out_data, shared_out_o, shared_out_oe;
  logic        free_io_pullup, free_io_pulldown, design_switch, eos_out, config_done, user_reset;
  logic        user_lnk_up, irq, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [1:0]  s_bresp, s_rresp;
  int          error_cnt, tests_run, done_cnt, i;

  schf_handoff DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .eos_in(eos_in),
    .stage2_load_start(stage2_load_start), .link_ok(link_ok), .pullup_during_config_n(pullup_during_config_n),
    .user_crit_in(user_crit_in), .core_crit_out(core_crit_out), .tlp_unhandled(tlp_unhandled),
    .tlp_unsupported(tlp_unsupported), .tlp_to_user(tlp_to_user), .shared_out_data(shared_out_data),
    .shared_out_o(shared_out_o), .shared_out_oe(shared_out_oe), .free_io_pullup(free_io_pullup),
    .free_io_pulldown(free_io_pulldown), .design_switch(design_switch), .eos_out(eos_out),
    .config_done(config_done), .user_reset(user_reset), .user_lnk_up(user_lnk_up), .irq(irq),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

  schf_user_model PARTNER (.aclk(aclk), .user_reset(user_reset), .user_crit_in(user_crit_in),
    .shared_out_data(shared_out_data));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Counts cycles with the done pin high, so a one-cycle pulse is not missed
  always @(negedge aclk) begin
    if (config_done === 1'b1) done_cnt++;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tmo();
    error_cnt++;
    $display("mismatch at %0t: bus answer timed out", $time);
    finish_test();
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    int   n;
    @(posedge aclk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (s_bvalid === 1'b1) break;
      ta = s_awvalid & s_awready;
      tw = s_wvalid & s_wready;
      @(posedge aclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
    end
    if (n == 50) tmo();
    chk(s_bresp, er);
    @(posedge aclk);
    s_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      if (s_rvalid === 1'b1) break;
      if (s_arvalid & s_arready) begin
        @(posedge aclk);
        s_arvalid <= 1'b0;
      end
    end
    if (n == 50) tmo();
    chk(s_rdata, ed);
    chk(s_rresp, er);
    @(posedge aclk);
    s_rready <= 1'b0;
  endtask

  initial begin
    {aresetn, eos_in, stage2_load_start, link_ok, pullup_during_config_n, tlp_unhandled} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    ce = 1'b1;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'hF;
    error_cnt = 0;
    tests_run = 0;
    repeat (11) @(posedge aclk);
    step(1);
    chk(user_reset, 1'b1);
    chk(design_switch, 1'b0);
    @(posedge aclk) aresetn <= 1'b1;
    step(2);
    chk(user_reset, 1'b1);
    step(6);
    chk(user_reset, 1'b0);
    $display("test reset done");
    for (i = 0; i < 6; i++) axi_rd(rows[i].a, rows[i].d, rows[i].r);
    $display("test register table done");
    axi_wr(8'h14, 32'h0000_0001, SCHF_RESP_ERR);
    axi_wr(8'h0C, 32'h0000_0001, SCHF_RESP_OK);
    axi_wr(8'h00, 32'h0000_0002, SCHF_RESP_OK);
    @(posedge aclk) tlp_unhandled <= 1'b1;
    step(2);
    chk(eos_out, 1'b0);
    chk(free_io_pulldown, 1'b0);
    done_cnt = 0;
    // Startup primitive lives outside, well inside the link deadline
    @(posedge aclk) eos_in <= 1'b1;
    step(8);
    chk(eos_out, 1'b1);
    chk(done_cnt, 1);
    chk(free_io_pulldown, 1'b1);
    chk(irq, 1'b1);
    chk({design_switch, shared_out_oe, core_crit_out}, 6'h00);
    chk({tlp_unsupported, tlp_to_user}, 2'b10);
    axi_wr(8'h08, 32'h0000_0001, SCHF_RESP_OK);
    step(1);
    chk(irq, 1'b0);
    $display("test stage one done");
    @(posedge aclk) eos_in <= 1'b0;
    stage2_load_start <= 1'b1;
    step(8);
    chk(config_done, 1'b0);
    chk(eos_out, 1'b0);
    chk(free_io_pullup, 1'b1);
    chk({design_switch, shared_out_oe}, 2'b00);
    @(posedge aclk) pullup_during_config_n <= 1'b1;
    link_ok <= 1'b1;
    step(8);
    chk(free_io_pullup, 1'b0);
    chk(user_lnk_up, 1'b1);
    $display("test stage two load done");
    @(posedge aclk) eos_in <= 1'b1;
    step(8);
    chk({design_switch, config_done, eos_out}, 3'b111);
    chk(shared_out_oe, 1'b1);
    chk(shared_out_o, !shared_out_data);
    chk(core_crit_out, 4'(user_crit_in - 4'h1));
    chk({tlp_unsupported, tlp_to_user}, 2'b01);
    axi_rd(8'h04, 32'h0000_000F, SCHF_RESP_OK);
    @(posedge aclk) eos_in <= 1'b0;
    link_ok <= 1'b0;
    step(8);
    chk({design_switch, config_done}, 2'b11);
    chk(user_lnk_up, 1'b0);
    $display("test handoff done");
    // Software reset of the user side leaves the handoff alone
    axi_wr(8'h00, 32'h0000_0003, SCHF_RESP_OK);
    step(1);
    chk({user_reset, design_switch}, 2'b11);
    axi_wr(8'h00, 32'h0000_0002, SCHF_RESP_OK);
    step(8);
    chk(user_reset, 1'b0);
    $display("test soft reset done");
    // Enable low freezes the link flag and the bus
    @(posedge aclk) ce <= 1'b0;
    link_ok <= 1'b1;
    step(8);
    chk({user_lnk_up, s_arready, s_awready}, 3'b000);
    @(posedge aclk) ce <= 1'b1;
    step(8);
    chk(user_lnk_up, 1'b1);
    $display("test clock enable done");
    @(posedge aclk) aresetn <= 1'b0;
    stage2_load_start <= 1'b0;
    step(2);
    chk({design_switch, user_reset}, 2'b01);
    @(posedge aclk) aresetn <= 1'b1;
    step(2);
    chk({design_switch, user_reset}, 2'b01);
    step(6);
    chk(user_reset, 1'b0);
    $display("test second reset done");
    // Stored-flash case: software starts the second load
    done_cnt = 0;
    @(posedge aclk) eos_in <= 1'b1;
    step(8);
    chk(done_cnt, 1);
    chk(eos_out, 1'b1);
    axi_wr(8'h00, 32'h0000_0008, SCHF_RESP_OK);
    step(1);
    axi_rd(8'h04, 32'h0000_0022, SCHF_RESP_OK);
    chk(free_io_pullup, 1'b0);
    @(posedge aclk) eos_in <= 1'b0;
    step(4);
    @(posedge aclk) eos_in <= 1'b1;
    step(8);
    chk({design_switch, config_done}, 2'b11);
    $display("test software load done");
    finish_test();
  end
endmodule
